// ### rtl/rde_pkg.sv
// shared constants for the line direction and enable control block
package rde_pkg;

    // register bus geometry
    localparam int RDE_ADDR_W = 4;
    localparam int RDE_DATA_W = 8;

    // register byte offsets
    localparam logic [3:0] RDE_CTRL_OFS = 4'h0;
    localparam logic [3:0] RDE_STAT_OFS = 4'h4;

    // control register field positions
    localparam int RDE_CTRL_TXM_LSB = 0;
    localparam int RDE_CTRL_RXM_LSB = 2;

    // status register field positions
    localparam int RDE_STAT_DRV_BIT = 0;
    localparam int RDE_STAT_RCV_BIT = 1;
    localparam int RDE_STAT_ACT_BIT = 2;

    // enable mode encoding, shared by transmitter and receiver selection
    typedef enum logic [1:0] {
        RDE_MODE_AUTO = 2'h0,
        RDE_MODE_RTS = 2'h1,
        RDE_MODE_P2P = 2'h2
    } rde_mode_t;

    // reset values: both selections start in automatic mode
    localparam logic [1:0] RDE_TXM_RST = 2'h0;
    localparam logic [1:0] RDE_RXM_RST = 2'h0;

    // automatic transmit sequencer states, gray coded
    typedef enum logic [0:0] {
        RDE_ST_IDLE = 1'b0,
        RDE_ST_SEND = 1'b1
    } rde_state_t;

endpackage

// ### rtl/rde_dir_ctrl.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none

module rde_dir_ctrl
    import rde_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [RDE_ADDR_W-1:0] reg_addr,
    input wire logic [RDE_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [RDE_DATA_W-1:0] reg_rdata,
    // uart side, same clock
    input wire logic uart_txd,
    input wire logic uart_tx_empty,
    input wire logic uart_rts,
    input wire logic uart_dtr,
    output logic uart_rxd,
    output logic uart_cts,
    output logic uart_dsr,
    output logic uart_dcd,
    // line side pins
    input wire logic line_rxd,
    input wire logic line_cts,
    input wire logic line_dsr,
    input wire logic line_dcd,
    output logic line_txd,
    output logic line_tx_oe,
    output logic line_rx_en,
    output logic line_rts,
    output logic line_dtr
);

    // configuration registers
    logic [1:0] tx_mode_reg; // transmitter enable selection
    logic [1:0] rx_mode_reg; // receiver enable selection

    // sequencer
    rde_state_t state_reg;
    rde_state_t state_next;

    // line input synchronisers, bit 3 rxd, 2 cts, 1 dsr, 0 dcd
    logic [3:0] pin_in;
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;

    // mode decode; an unused code falls back to automatic
    wire tx_is_p2p = (tx_mode_reg == RDE_MODE_P2P);
    wire tx_is_rts = (tx_mode_reg == RDE_MODE_RTS);
    wire tx_is_auto = !tx_is_p2p && !tx_is_rts;
    wire rx_is_p2p = (rx_mode_reg == RDE_MODE_P2P);
    wire rx_is_rts = (rx_mode_reg == RDE_MODE_RTS);
    wire rx_is_auto = !rx_is_p2p && !rx_is_rts;

    // register decode
    wire wr_ctrl = reg_wr && (reg_addr == RDE_CTRL_OFS);
    wire rd_ctrl = reg_rd && (reg_addr == RDE_CTRL_OFS);
    wire rd_stat = reg_rd && (reg_addr == RDE_STAT_OFS);

    // sequencer events
    wire start_bit = (state_reg == RDE_ST_IDLE) && !uart_txd;
    wire tx_done = (state_reg == RDE_ST_SEND) && uart_tx_empty && uart_txd;
    wire auto_active_next = (state_next == RDE_ST_SEND);

    // next values of the line side flops and of the read data flop
    logic drive_next;
    logic rcv_next;
    logic [RDE_DATA_W-1:0] rdata_next;

    assign pin_in = {line_rxd, line_cts, line_dsr, line_dcd};

    // two flops per pin; the first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    // idle line level is high for data and low for modem lines
                    pin_s1_reg[gi] <= (gi == 3) ? 1'b1 : 1'b0;
                    pin_s2_reg[gi] <= (gi == 3) ? 1'b1 : 1'b0;
                end else begin
                    pin_s1_reg[gi] <= pin_in[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                end
            end
        end
    endgenerate

    // control register write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_mode_reg <= RDE_TXM_RST;
            rx_mode_reg <= RDE_RXM_RST;
        end else if (wr_ctrl) begin
            tx_mode_reg <= reg_wdata[RDE_CTRL_TXM_LSB +: 2];
            rx_mode_reg <= reg_wdata[RDE_CTRL_RXM_LSB +: 2];
        end
    end

    // automatic sequencer: start bit opens, empty uart closes
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RDE_ST_IDLE: begin
                if (start_bit) begin
                    state_next = RDE_ST_SEND;
                end
            end
            RDE_ST_SEND: begin
                // both holding and shift empty, stop bit back to mark
                if (tx_done) begin
                    state_next = RDE_ST_IDLE;
                end
            end
        endcase
    end

    // sequencer runs in every mode so a mode change lands cleanly
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= RDE_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // driver enable per selection
    always_comb begin
        if (tx_is_p2p) begin
            drive_next = 1'b1;
        end else if (tx_is_rts) begin
            drive_next = uart_rts;
        end else begin
            // released whenever idle so another node may talk
            drive_next = auto_active_next;
        end
    end

    // receiver enable per selection
    always_comb begin
        if (rx_is_p2p) begin
            rcv_next = 1'b1;
        end else if (rx_is_rts) begin
            // listening while not asking for the line
            rcv_next = !uart_rts;
        end else begin
            // deaf while our own frame is on the wire
            rcv_next = !auto_active_next;
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        rdata_next = '0;
        if (rd_ctrl) begin
            rdata_next[RDE_CTRL_TXM_LSB +: 2] = tx_mode_reg;
            rdata_next[RDE_CTRL_RXM_LSB +: 2] = rx_mode_reg;
        end else if (rd_stat) begin
            rdata_next[RDE_STAT_DRV_BIT] = line_tx_oe;
            rdata_next[RDE_STAT_RCV_BIT] = line_rx_en;
            rdata_next[RDE_STAT_ACT_BIT] = (state_reg == RDE_ST_SEND);
        end
    end

    // output flops; data and enable move together so the start bit is not clipped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            line_txd <= 1'b1;
            line_tx_oe <= 1'b0;
            line_rx_en <= 1'b0;
            line_rts <= 1'b0;
            line_dtr <= 1'b0;
            uart_rxd <= 1'b1;
            uart_cts <= 1'b0;
            uart_dsr <= 1'b0;
            uart_dcd <= 1'b0;
            reg_rdata <= '0;
        end else begin
            line_txd <= uart_txd;
            line_tx_oe <= drive_next;
            line_rx_en <= rcv_next;
            // modem outputs only meaningful on a point to point link
            line_rts <= tx_is_p2p && uart_rts;
            line_dtr <= tx_is_p2p && uart_dtr;
            // disabled receiver looks like an idle mark line
            uart_rxd <= rcv_next ? pin_s2_reg[3] : 1'b1;
            uart_cts <= rx_is_p2p && pin_s2_reg[2];
            uart_dsr <= rx_is_p2p && pin_s2_reg[1];
            uart_dcd <= rx_is_p2p && pin_s2_reg[0];
            reg_rdata <= rdata_next;
        end
    end

    // checks
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_P2P_DRIVE: assert property (
        tx_is_p2p |=> line_tx_oe
    ) else $error("driver not on in always-on mode");

    AST_RTS_DRIVE: assert property (
        tx_is_rts |=> (line_tx_oe == $past(uart_rts))
    ) else $error("driver enable does not follow rts");

    // a start bit seen on the last reset edge cannot open the driver yet
    AST_AUTO_START: assert property (
        (!rst && tx_is_auto && start_bit) |=> (line_tx_oe && !line_txd)
    ) else $error("driver not on with start bit");

    AST_AUTO_HOLD: assert property (
        (tx_is_auto && (state_reg == RDE_ST_SEND) && !uart_tx_empty) |=> line_tx_oe
    ) else $error("driver dropped while uart still sending");

    AST_AUTO_STOP: assert property (
        (tx_is_auto && tx_done) ##1 tx_is_auto && uart_txd |=> !line_tx_oe
    ) else $error("driver not released after frame");

    AST_MODEM_OUT: assert property (
        !tx_is_p2p |=> (!line_rts && !line_dtr)
    ) else $error("modem outputs leaked outside always-on mode");

    AST_RX_RTS: assert property (
        rx_is_rts |=> (line_rx_en == !$past(uart_rts))
    ) else $error("receiver enable not derived from rts");

    // last reset edge left out: both enables still show their reset levels there
    AST_RX_AUTO: assert property (
        (!rst && rx_is_auto && tx_is_auto) |=> (line_rx_en != line_tx_oe)
    ) else $error("auto receiver open during own transmit");

    AST_MODEM_IN: assert property (
        !rx_is_p2p |=> (!uart_cts && !uart_dsr && !uart_dcd)
    ) else $error("modem inputs passed outside always-on mode");

    AST_ECHO: assert property (
        rx_is_p2p |=> (line_rx_en && (uart_rxd == $past(pin_s2_reg[3])))
    ) else $error("always-on receiver does not pass line data");

    AST_RX_MARK: assert property (
        !line_rx_en |-> uart_rxd
    ) else $error("disabled receiver not idle high");

    AST_CTRL_READ: assert property (
        (reg_rd && (reg_addr == RDE_CTRL_OFS)) |=>
            (reg_rdata[3:0] == {$past(rx_mode_reg), $past(tx_mode_reg)})
    ) else $error("control readback wrong");

    // line data lags the uart by exactly one flop, in every mode
    AST_TXD_COPY: assert property (
        !rst |=> (line_txd == $past(uart_txd))
    ) else $error("line data is not the delayed uart data");

    // release comes on the edge right after the frame ends
    AST_AUTO_RELEASE: assert property (
        (!rst && tx_is_auto && tx_done) |=> !line_tx_oe
    ) else $error("driver held past end of frame");

    // always-on mode hands the uart modem levels to the line
    AST_MODEM_PASS: assert property (
        (!rst && tx_is_p2p) |=>
            ((line_rts == $past(uart_rts)) && (line_dtr == $past(uart_dtr)))
    ) else $error("modem outputs not passed in always-on mode");

    // always-on receiver hands the synchronised modem pins to the uart
    AST_MODEM_IN_PASS: assert property (
        (!rst && rx_is_p2p) |=> ((uart_cts == $past(pin_s2_reg[2]))
            && (uart_dsr == $past(pin_s2_reg[1])) && (uart_dcd == $past(pin_s2_reg[0])))
    ) else $error("modem inputs not passed in always-on mode");

    // read data stands one cycle only, zero otherwise
    AST_RDATA_IDLE: assert property (
        !reg_rd |=> (reg_rdata == '0)
    ) else $error("read data not cleared outside a read");

    // status shows the enables as they stood at the read strobe
    AST_STAT_READ: assert property (
        (reg_rd && (reg_addr == RDE_STAT_OFS)) |=>
            ((reg_rdata[RDE_STAT_DRV_BIT] == $past(line_tx_oe))
            && (reg_rdata[RDE_STAT_RCV_BIT] == $past(line_rx_en)))
    ) else $error("status readback wrong");

    COV_AUTO_FRAME: cover property (
        tx_is_auto && start_bit ##[1:1000] tx_done
    );
    COV_RTS_DRIVE: cover property (tx_is_rts && uart_rts ##1 line_tx_oe);
    COV_P2P_MODEM: cover property (rx_is_p2p && pin_s2_reg[2] ##1 uart_cts);
    COV_MODE_WRITE: cover property (wr_ctrl ##1 tx_is_p2p);
    COV_RX_RTS_LISTEN: cover property (rx_is_rts && !uart_rts ##1 line_rx_en);

endmodule

`default_nettype wire

// ### tb/rde_bus_node.sv
`timescale 1ns/10ps
`default_nettype none

// far node on a shared two-wire bus, our tx strapped to our rx
module rde_bus_node (
    input wire logic line_txd,
    input wire logic line_tx_oe,
    input wire logic node_drive,
    input wire logic node_bit,
    output logic bus_level
);
    // node talks only while our driver is released, never over it
    wire node_oe = node_drive & ~line_tx_oe;
    // wired bus: our driver, else node, else bias pull-up to idle
    assign bus_level = line_tx_oe ? line_txd : (node_oe ? node_bit : 1'b1);
endmodule

`default_nettype wire

// ### tb/tb_rs485_direction_enable_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module tb_rs485_direction_enable_ctrl;
    import rde_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd;
    logic [RDE_ADDR_W-1:0] reg_addr;
    logic [RDE_DATA_W-1:0] reg_wdata, reg_rdata;
    logic uart_txd, uart_tx_empty, uart_rts, uart_dtr, uart_rxd, uart_cts, uart_dsr, uart_dcd;
    logic line_rxd, line_cts, line_dsr, line_dcd;
    logic line_txd, line_tx_oe, line_rx_en, line_rts, line_dtr, node_drive, node_bit;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    rde_dir_ctrl dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uart_txd(uart_txd),
        .uart_tx_empty(uart_tx_empty), .uart_rts(uart_rts), .uart_dtr(uart_dtr),
        .uart_rxd(uart_rxd), .uart_cts(uart_cts), .uart_dsr(uart_dsr), .uart_dcd(uart_dcd),
        .line_rxd(line_rxd), .line_cts(line_cts), .line_dsr(line_dsr), .line_dcd(line_dcd),
        .line_txd(line_txd), .line_tx_oe(line_tx_oe), .line_rx_en(line_rx_en),
        .line_rts(line_rts), .line_dtr(line_dtr));
    rde_bus_node node (.line_txd(line_txd), .line_tx_oe(line_tx_oe), .node_drive(node_drive),
        .node_bit(node_bit), .bus_level(line_rxd));

    // free running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // hang guard, well above the ninety or so cycles used
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one-cycle strobes, released at the next edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data valid only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp, "register read");
    endtask

    // packed line side: oe, rx_en, txd, rts, dtr
    task automatic pins(input logic [7:0] e);
        #1 chk({3'h0, line_tx_oe, line_rx_en, line_txd, line_rts, line_dtr}, e, "line pins");
    endtask

    // packed uart side: rxd, cts, dsr, dcd
    task automatic ups(input logic [7:0] e);
        #1 chk({4'h0, uart_rxd, uart_cts, uart_dsr, uart_dcd}, e, "uart side");
    endtask

    // uart levels plus one level for all three modem pins
    task automatic drv(input logic t, input logic e, input logic r, input logic d, input logic m);
        @(posedge clk_sys);
        uart_txd <= t;
        uart_tx_empty <= e;
        uart_rts <= r;
        uart_dtr <= d;
        line_cts <= m;
        line_dsr <= m;
        line_dcd <= m;
    endtask

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {uart_txd, uart_tx_empty, uart_rts, uart_dtr} = 4'hC;
        {line_cts, line_dsr, line_dcd, node_drive, node_bit} = 5'h01;
        tick(8);
        rst <= 1'b0;
        tick(3);
        rd(RDE_CTRL_OFS, 8'h00);
        rd(RDE_STAT_OFS, 8'h02);
        pins(8'h0C);
        // unmapped and read-only places ignore writes
        wr(4'h8, 8'h0A);
        wr(RDE_STAT_OFS, 8'hFF);
        rd(4'h8, 8'h00);
        rd(RDE_CTRL_OFS, 8'h00);
        // automatic: start bit, data, stop, then a back-to-back character
        drv(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        tick(1);
        pins(8'h10);
        rd(RDE_STAT_OFS, 8'h05);
        drv(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        tick(1);
        pins(8'h14);
        tick(3);
        ups(8'h08);
        drv(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        tick(1);
        pins(8'h0C);
        drv(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        tick(1);
        pins(8'h10);
        drv(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        tick(1);
        pins(8'h0C);
        // other node answers while we listen
        @(posedge clk_sys);
        node_drive <= 1'b1;
        node_bit <= 1'b0;
        tick(4);
        ups(8'h00);
        @(posedge clk_sys);
        node_drive <= 1'b0;
        // rts selection on both sides suppresses echo
        wr(RDE_CTRL_OFS, 8'h05);
        drv(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        tick(1);
        pins(8'h14);
        drv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        tick(1);
        pins(8'h08);
        // independent selections: tx by rts, rx always on, echo seen
        wr(RDE_CTRL_OFS, 8'h09);
        drv(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        tick(1);
        pins(8'h1C);
        drv(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
        tick(4);
        ups(8'h07);
        // always-on on both sides
        wr(RDE_CTRL_OFS, 8'h0A);
        drv(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        tick(1);
        pins(8'h1F);
        drv(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        tick(4);
        pins(8'h19);
        ups(8'h07);
        rd(RDE_CTRL_OFS, 8'h0A);
        rd(RDE_STAT_OFS, 8'h07);
        // reset in mid-run returns to automatic
        drv(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        tick(3);
        rd(RDE_CTRL_OFS, 8'h00);
        pins(8'h0C);
        // unused code is kept but acts as automatic
        wr(RDE_CTRL_OFS, 8'h0F);
        rd(RDE_CTRL_OFS, 8'h0F);
        drv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        tick(1);
        pins(8'h10);
        drv(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        tick(1);
        pins(8'h0C);
        conclude();
    end
endmodule

`default_nettype wire
